// [src/rdsc_top.sv]
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Codes 0,1,2: signal losses, lock loss
// - Codes 3,4,11: divider outputs halved
// - Codes 8,13,14: calibration, memory, switch
// - Code 10: interrupt from flag bits
// - Pin B selector bits 7:4, resets lock-loss
// - Pin A polarity bit 3, resets high
// - Pin B polarity bit 3, resets high
// - Test override beats selector and polarity
// - Bypass bit 7 makes both inputs valid
// - Bypass leaves flags and pins untouched
// - Second detect method bits 7:6, reset 1
// - First detect method bits 5:4, reset 1
// - Second comparator level bits 3:2, reset 1
// - First comparator level bits 1:0, reset 1
// - Bits 5,4 enable ground terminations
// - Bits 3,2 enable differential terminations
// - Bits 1,0 enable AC input biasing
module rdsc_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic first_signal_loss_raw,
  input wire logic second_signal_loss_raw,
  input wire logic lock_loss_raw,
  input wire logic ref_div_clk,
  input wire logic fb_div_clk,
  input wire logic third_div_clk,
  input wire logic vco_cal_raw,
  input wire logic nvm_active_raw,
  input wire logic auto_switch_raw,
  input wire logic [7:0] interrupt_flags_raw,
  input wire logic ref_div_bypassed,
  input wire logic third_div_bypassed,
  input wire logic test_override,
  input wire logic test_pin_a,
  input wire logic test_pin_b,
  output logic status_pin_a,
  output logic status_pin_b,
  output logic first_reference_valid,
  output logic second_reference_valid,
  output rdsc_pkg::rdsc_input_cfg_s input_cfg
);
  localparam int SYNC_W = 17;

  logic [7:0] reference_detect_control;
  logic [7:0] status_pin_a_select_polarity;
  logic [7:0] status_pin_b_select_polarity;
  logic [7:0] input_reference_control;
  logic wr_req;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic wr_lane;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_in;
  logic [2:0] div_last;
  logic [2:0] div_half;
  logic [3:0] sel_a;
  logic [3:0] sel_b;
  logic pol_a;
  logic pol_b;
  logic detector_bypass;
  rdsc_pkg::rdsc_evt_s evt;

  rdsc_axil_slave u_bus (
    .ref_clk(ref_clk),
    .rst(rst),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_req(wr_req),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // Address decode, shared by both directions
  function automatic logic reg_hit(input logic [11:0] a);
    return a == rdsc_pkg::rdsc_byte_addr(rdsc_pkg::IDX_REFERENCE_DETECT_CONTROL)
      || a == rdsc_pkg::rdsc_byte_addr(rdsc_pkg::IDX_STATUS_PIN_A_SELECT_POLARITY)
      || a == rdsc_pkg::rdsc_byte_addr(rdsc_pkg::IDX_STATUS_PIN_B_SELECT_POLARITY)
      || a == rdsc_pkg::rdsc_byte_addr(rdsc_pkg::IDX_INPUT_REFERENCE_CONTROL);
  endfunction : reg_hit

  assign wr_ok = reg_hit(wr_addr);
  assign rd_ok = reg_hit(rd_addr);
  // Registers are a byte wide, so only lane 0 carries data
  assign wr_lane = wr_req && wr_strb[0];

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      reference_detect_control <= rdsc_pkg::RST_REFERENCE_DETECT_CONTROL;
    else if (wr_lane && wr_addr == rdsc_pkg::rdsc_byte_addr(
        rdsc_pkg::IDX_REFERENCE_DETECT_CONTROL))
      reference_detect_control <= wr_data[7:0];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      status_pin_a_select_polarity <= rdsc_pkg::RST_STATUS_PIN_A_SELECT_POLARITY;
    else if (wr_lane && wr_addr == rdsc_pkg::rdsc_byte_addr(
        rdsc_pkg::IDX_STATUS_PIN_A_SELECT_POLARITY))
      status_pin_a_select_polarity <= wr_data[7:0] & rdsc_pkg::MASK_STATUS_SELECT_POLARITY;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      status_pin_b_select_polarity <= rdsc_pkg::RST_STATUS_PIN_B_SELECT_POLARITY;
    else if (wr_lane && wr_addr == rdsc_pkg::rdsc_byte_addr(
        rdsc_pkg::IDX_STATUS_PIN_B_SELECT_POLARITY))
      status_pin_b_select_polarity <= wr_data[7:0] & rdsc_pkg::MASK_STATUS_SELECT_POLARITY;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      input_reference_control <= rdsc_pkg::RST_INPUT_REFERENCE_CONTROL;
    else if (wr_lane && wr_addr == rdsc_pkg::rdsc_byte_addr(
        rdsc_pkg::IDX_INPUT_REFERENCE_CONTROL))
      input_reference_control <= wr_data[7:0] & rdsc_pkg::MASK_INPUT_REFERENCE_CONTROL;
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      rdsc_pkg::rdsc_byte_addr(rdsc_pkg::IDX_REFERENCE_DETECT_CONTROL):
        rd_data[7:0] = reference_detect_control;
      rdsc_pkg::rdsc_byte_addr(rdsc_pkg::IDX_STATUS_PIN_A_SELECT_POLARITY):
        rd_data[7:0] = status_pin_a_select_polarity;
      rdsc_pkg::rdsc_byte_addr(rdsc_pkg::IDX_STATUS_PIN_B_SELECT_POLARITY):
        rd_data[7:0] = status_pin_b_select_polarity;
      rdsc_pkg::rdsc_byte_addr(rdsc_pkg::IDX_INPUT_REFERENCE_CONTROL):
        rd_data[7:0] = input_reference_control;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  assign sel_a = status_pin_a_select_polarity[rdsc_pkg::POS_SELECTOR +: 4];
  assign sel_b = status_pin_b_select_polarity[rdsc_pkg::POS_SELECTOR +: 4];
  assign pol_a = status_pin_a_select_polarity[rdsc_pkg::POS_POLARITY];
  assign pol_b = status_pin_b_select_polarity[rdsc_pkg::POS_POLARITY];
  assign detector_bypass = input_reference_control[rdsc_pkg::POS_DETECTOR_BYPASS];

  always_comb
  begin
    input_cfg.second_input_detect_method =
      reference_detect_control[rdsc_pkg::POS_SECOND_DETECT_METHOD +: 2];
    input_cfg.first_input_detect_method =
      reference_detect_control[rdsc_pkg::POS_FIRST_DETECT_METHOD +: 2];
    input_cfg.second_input_comparator_level =
      reference_detect_control[rdsc_pkg::POS_SECOND_LEVEL +: 2];
    input_cfg.first_input_comparator_level =
      reference_detect_control[rdsc_pkg::POS_FIRST_LEVEL +: 2];
    input_cfg.second_input_ground_termination =
      input_reference_control[rdsc_pkg::POS_SECOND_GROUND_TERM];
    input_cfg.first_input_ground_termination =
      input_reference_control[rdsc_pkg::POS_FIRST_GROUND_TERM];
    input_cfg.second_input_diff_termination =
      input_reference_control[rdsc_pkg::POS_SECOND_DIFF_TERM];
    input_cfg.first_input_diff_termination =
      input_reference_control[rdsc_pkg::POS_FIRST_DIFF_TERM];
    input_cfg.second_input_ac_bias =
      input_reference_control[rdsc_pkg::POS_SECOND_AC_BIAS];
    input_cfg.first_input_ac_bias =
      input_reference_control[rdsc_pkg::POS_FIRST_AC_BIAS];
  end

  assign raw_in = {first_signal_loss_raw, second_signal_loss_raw, lock_loss_raw,
                   ref_div_clk, fb_div_clk, third_div_clk, vco_cal_raw,
                   nvm_active_raw, auto_switch_raw, interrupt_flags_raw};

  // Detector and PLL signals are asynchronous to ref_clk
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_meta <= '0;
      sync_in <= '0;
    end
    else
    begin
      sync_meta <= raw_in;
      sync_in <= sync_meta;
    end
  end

  // Halving toggles; divider clocks must stay below ref_clk over two
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      div_last <= 3'h0;
      div_half <= 3'h0;
    end
    else
    begin
      div_last <= sync_in[13:11];
      div_half <= div_half ^ (sync_in[13:11] & ~div_last);
    end
  end

  always_comb
  begin
    evt.first_signal_loss = sync_in[16];
    evt.second_signal_loss = sync_in[15];
    evt.lock_loss = sync_in[14];
    evt.ref_div_half = div_half[2] && !ref_div_bypassed;
    evt.fb_div_half = div_half[1];
    evt.third_div_half = div_half[0] && !third_div_bypassed;
    evt.vco_cal = sync_in[10];
    evt.nvm_active = sync_in[9];
    evt.auto_switch = sync_in[8];
    evt.interrupt_indication = |sync_in[7:0];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      first_reference_valid <= 1'b0;
      second_reference_valid <= 1'b0;
    end
    else
    begin
      first_reference_valid <= detector_bypass || !evt.first_signal_loss;
      second_reference_valid <= detector_bypass || !evt.second_signal_loss;
    end
  end

  rdsc_status_mux u_pin_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .sel(sel_a),
    .pol(pol_a),
    .evt(evt),
    .test_active(test_override),
    .test_level(test_pin_a),
    .pin(status_pin_a)
  );

  rdsc_status_mux u_pin_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .sel(sel_b),
    .pol(pol_b),
    .evt(evt),
    .test_active(test_override),
    .test_level(test_pin_b),
    .pin(status_pin_b)
  );

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_loss_route_a: assert property (
    !test_override && sel_a == rdsc_pkg::SEL_FIRST_SIGNAL_LOSS
    |=> status_pin_a == ($past(evt.first_signal_loss) ~^ $past(pol_a)))
    else $error("pin A does not follow first signal loss");
  a_lock_route_b: assert property (
    !test_override && sel_b == rdsc_pkg::SEL_LOCK_LOSS && pol_b
    |=> status_pin_b == $past(evt.lock_loss))
    else $error("pin B does not follow lock loss");
  a_div_halving: assert property (
    $rose(div_half[1]) |-> $past(sync_in[12]) && !$past(div_last[1]))
    else $error("feedback halving toggled without a rising edge");
  a_misc_route: assert property (
    !test_override && sel_a == rdsc_pkg::SEL_VCO_CAL && pol_a
    ##1 !test_override && sel_a == rdsc_pkg::SEL_VCO_CAL
    |=> status_pin_a == ($past(evt.vco_cal) ~^ $past(pol_a)))
    else $error("pin A does not show calibration");
  a_interrupt_indication_route: assert property (
    !test_override && sel_b == rdsc_pkg::SEL_INTERRUPT && pol_b
    && sync_in[7:0] != 8'h00 |=> status_pin_b)
    else $error("pin B misses the interrupt indication");
  a_pol_low: assert property (
    !test_override && !pol_a && sel_a == rdsc_pkg::SEL_SECOND_SIGNAL_LOSS
    && evt.second_signal_loss |=> !status_pin_a)
    else $error("pin A not active low with polarity clear");
  a_test_wins: assert property (
    test_override |=> status_pin_a == $past(test_pin_a)
    && status_pin_b == $past(test_pin_b))
    else $error("test override lost to the selectors");
  a_bypass_valid: assert property (
    detector_bypass |=> first_reference_valid && second_reference_valid)
    else $error("bypass did not force both inputs valid");
  a_no_bypass_pin: assert property (
    detector_bypass && !test_override && pol_b
    && sel_b == rdsc_pkg::SEL_FIRST_SIGNAL_LOSS && evt.first_signal_loss
    |=> status_pin_b)
    else $error("bypass masked a signal loss on pin B");
  a_reserved_zero: assert property (
    status_pin_a_select_polarity[2:0] == 3'h0 && status_pin_b_select_polarity[2:0] == 3'h0
    && input_reference_control[6] == 1'b0)
    else $error("reserved register bits are not zero");
  a_wr_resp: assert property (
    wr_req |=> s_axi_bvalid)
    else $error("write response missing");

  c_bypass_set: cover property (detector_bypass && evt.first_signal_loss);
  c_interrupt_indication_pin: cover property (sel_b == rdsc_pkg::SEL_INTERRUPT && status_pin_b);
  c_test_mode: cover property (test_override ##1 !test_override);
  c_bad_addr: cover property (s_axi_bvalid && s_axi_bresp == rdsc_pkg::RESP_SLVERR);
endmodule : rdsc_top

// [src/rdsc_pkg.sv]
package rdsc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_REFERENCE_DETECT_CONTROL = 8'h19;
  localparam logic [7:0] IDX_STATUS_PIN_A_SELECT_POLARITY = 8'h1b;
  localparam logic [7:0] IDX_STATUS_PIN_B_SELECT_POLARITY = 8'h1c;
  localparam logic [7:0] IDX_INPUT_REFERENCE_CONTROL = 8'h1d;

  localparam logic [7:0] RST_REFERENCE_DETECT_CONTROL = 8'h55;
  localparam logic [7:0] RST_STATUS_PIN_A_SELECT_POLARITY = 8'h58;
  localparam logic [7:0] RST_STATUS_PIN_B_SELECT_POLARITY = 8'h28;
  localparam logic [7:0] RST_INPUT_REFERENCE_CONTROL = 8'h06;

  localparam logic [7:0] MASK_STATUS_SELECT_POLARITY = 8'hf8;
  localparam logic [7:0] MASK_INPUT_REFERENCE_CONTROL = 8'hbf;

  localparam int POS_SECOND_DETECT_METHOD = 6;
  localparam int POS_FIRST_DETECT_METHOD = 4;
  localparam int POS_SECOND_LEVEL = 2;
  localparam int POS_FIRST_LEVEL = 0;
  localparam int POS_SELECTOR = 4;
  localparam int POS_POLARITY = 3;
  localparam int POS_DETECTOR_BYPASS = 7;
  localparam int POS_SECOND_GROUND_TERM = 5;
  localparam int POS_FIRST_GROUND_TERM = 4;
  localparam int POS_SECOND_DIFF_TERM = 3;
  localparam int POS_FIRST_DIFF_TERM = 2;
  localparam int POS_SECOND_AC_BIAS = 1;
  localparam int POS_FIRST_AC_BIAS = 0;

  localparam logic [3:0] SEL_FIRST_SIGNAL_LOSS = 4'h0;
  localparam logic [3:0] SEL_SECOND_SIGNAL_LOSS = 4'h1;
  localparam logic [3:0] SEL_LOCK_LOSS = 4'h2;
  localparam logic [3:0] SEL_REF_DIV_HALF = 4'h3;
  localparam logic [3:0] SEL_FB_DIV_HALF = 4'h4;
  localparam logic [3:0] SEL_VCO_CAL = 4'h8;
  localparam logic [3:0] SEL_INTERRUPT = 4'ha;
  localparam logic [3:0] SEL_THIRD_DIV_HALF = 4'hb;
  localparam logic [3:0] SEL_NVM_ACTIVE = 4'hd;
  localparam logic [3:0] SEL_AUTO_SWITCH = 4'he;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic first_signal_loss;
    logic second_signal_loss;
    logic lock_loss;
    logic ref_div_half;
    logic fb_div_half;
    logic third_div_half;
    logic vco_cal;
    logic interrupt_indication;
    logic nvm_active;
    logic auto_switch;
  } rdsc_evt_s;

  typedef struct packed {
    logic [1:0] second_input_detect_method;
    logic [1:0] first_input_detect_method;
    logic [1:0] second_input_comparator_level;
    logic [1:0] first_input_comparator_level;
    logic second_input_ground_termination;
    logic first_input_ground_termination;
    logic second_input_diff_termination;
    logic first_input_diff_termination;
    logic second_input_ac_bias;
    logic first_input_ac_bias;
  } rdsc_input_cfg_s;

  function automatic logic [11:0] rdsc_byte_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : rdsc_byte_addr
endpackage : rdsc_pkg

// [src/rdsc_status_mux.sv]
`timescale 1ns/1ps
module rdsc_status_mux (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] sel,
  input wire logic pol,
  input wire rdsc_pkg::rdsc_evt_s evt,
  input wire logic test_active,
  input wire logic test_level,
  output logic pin
);
  logic ind;

  always_comb
  begin
    case (sel)
      rdsc_pkg::SEL_FIRST_SIGNAL_LOSS: ind = evt.first_signal_loss;
      rdsc_pkg::SEL_SECOND_SIGNAL_LOSS: ind = evt.second_signal_loss;
      rdsc_pkg::SEL_LOCK_LOSS: ind = evt.lock_loss;
      rdsc_pkg::SEL_REF_DIV_HALF: ind = evt.ref_div_half;
      rdsc_pkg::SEL_FB_DIV_HALF: ind = evt.fb_div_half;
      rdsc_pkg::SEL_THIRD_DIV_HALF: ind = evt.third_div_half;
      rdsc_pkg::SEL_VCO_CAL: ind = evt.vco_cal;
      rdsc_pkg::SEL_NVM_ACTIVE: ind = evt.nvm_active;
      rdsc_pkg::SEL_AUTO_SWITCH: ind = evt.auto_switch;
      rdsc_pkg::SEL_INTERRUPT: ind = evt.interrupt_indication;
      // Reserved codes give an inactive indication
      default: ind = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      pin <= 1'b0;
    else if (test_active)
      pin <= test_level;
    else
      pin <= ind ~^ pol;
  end
endmodule : rdsc_status_mux

// [src/rdsc_axil_slave.sv]
`timescale 1ns/1ps
module rdsc_axil_slave (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_req,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [11:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_held;
  logic w_held;

  assign awready = !aw_held;
  assign wready = !w_held;
  // Only one write in flight: commit waits for the previous response
  assign wr_req = aw_held && w_held && !bvalid;
  assign arready = !rvalid;
  assign rd_addr = araddr;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      wr_addr <= 12'h000;
    end
    else if (awvalid && awready)
    begin
      aw_held <= 1'b1;
      wr_addr <= awaddr;
    end
    else if (wr_req)
      aw_held <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      w_held <= 1'b0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      w_held <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end
    else if (wr_req)
      w_held <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp <= rdsc_pkg::RESP_OKAY;
    end
    else if (wr_req)
    begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? rdsc_pkg::RESP_OKAY : rdsc_pkg::RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= rdsc_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_ok ? rdsc_pkg::RESP_OKAY : rdsc_pkg::RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end
endmodule : rdsc_axil_slave

// [verif/rdsc_board_mon.sv]
`timescale 1ns/1ps
// Board side: counts level changes seen on the two status pins
module rdsc_board_mon (
  input wire logic ref_clk,
  input wire logic status_pin_a,
  input wire logic status_pin_b,
  output int flips_a,
  output int flips_b
);
  logic last_a = 1'b0;
  logic last_b = 1'b0;
  initial flips_a = 0;
  initial flips_b = 0;
  // Pins are plain levels, so sampling once a clock misses nothing
  always @(posedge ref_clk)
  begin
    if (status_pin_a !== last_a)
      flips_a++;
    if (status_pin_b !== last_b)
      flips_b++;
    last_a = status_pin_a;
    last_b = status_pin_b;
  end
endmodule : rdsc_board_mon

// [verif/rdsc_top_tb_top.sv]
`timescale 1ns/1ps
module rdsc_top_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, pa, pb, v1, v2;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  rdsc_pkg::rdsc_input_cfg_s cfg;
  logic l1 = 1'b0, l2 = 1'b0, lck = 1'b0, cal = 1'b0, nvm = 1'b0, asw = 1'b0;
  logic rdc = 1'b0, fdc = 1'b0, tdc = 1'b0, rbyp = 1'b1, tbyp = 1'b1;
  logic tov = 1'b0, ta = 1'b0, tb = 1'b0;
  logic [7:0] flags = 8'h0;
  int num_errors = 0;
  int tests_run = 0;
  int fa, fb, sa, sb;
  logic [7:0] regs[4] = '{8'h55, 8'h58, 8'h28, 8'h06};
  logic [7:0] mask[4] = '{8'hff, 8'hf8, 8'hf8, 8'hbf};
  logic [11:0] addr[4] = '{12'h064, 12'h06c, 12'h070, 12'h074};
  logic [3:0] legal[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'ha, 4'hb, 4'hd, 4'he};

  rdsc_top uut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .first_signal_loss_raw(l1), .second_signal_loss_raw(l2), .lock_loss_raw(lck),
    .ref_div_clk(rdc), .fb_div_clk(fdc), .third_div_clk(tdc), .vco_cal_raw(cal),
    .nvm_active_raw(nvm), .auto_switch_raw(asw), .interrupt_flags_raw(flags),
    .ref_div_bypassed(rbyp), .third_div_bypassed(tbyp), .test_override(tov),
    .test_pin_a(ta), .test_pin_b(tb), .status_pin_a(pa), .status_pin_b(pb),
    .first_reference_valid(v1), .second_reference_valid(v2), .input_cfg(cfg));
  rdsc_board_mon mon (.ref_clk(ref_clk), .status_pin_a(pa), .status_pin_b(pb),
    .flips_a(fa), .flips_b(fb));

  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic give_verdict;
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask : chk_resp

  task automatic chk_pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk_pin

  // Halved divider codes are left out: their toggles are checked by counting
  function automatic logic ind(input logic [3:0] c);
    case (c)
      4'h0: return l1;
      4'h1: return l2;
      4'h2: return lck;
      4'h8: return cal;
      4'ha: return |flags;
      4'hd: return nvm;
      4'he: return asw;
      default: return 1'b0;
    endcase
  endfunction : ind

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    logic [1:0] er, got;
    logic aw_ok, w_ok, b_ok;
    int n;
    er = rdsc_pkg::RESP_SLVERR;
    got = 2'h1;
    for (int k = 0; k < 4; k++)
      if (addr[k] == a)
      begin
        er = rdsc_pkg::RESP_OKAY;
        if (s[0])
          regs[k] = d & mask[k];
      end
    @(posedge ref_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'ha5a5a5, d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 1'b0;
    for (n = 0; n < 50 && !b_ok; n++)
    begin
      #1;
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      got = bresp;
      @(posedge ref_clk);
      if (aw_ok)
        awvalid <= 1'b0;
      if (w_ok)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk_resp(got, er);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    logic [31:0] ed, gd;
    logic [1:0] er, gr;
    logic a_ok, r_ok;
    ed = 32'h0;
    er = rdsc_pkg::RESP_SLVERR;
    for (int k = 0; k < 4; k++)
      if (addr[k] == a)
      begin
        ed = {24'h0, regs[k]};
        er = rdsc_pkg::RESP_OKAY;
      end
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_ok = 1'b0;
    for (int n = 0; n < 50 && !r_ok; n++)
    begin
      #1;
      a_ok = arvalid && arready;
      r_ok = rvalid;
      gd = rdata;
      gr = rresp;
      @(posedge ref_clk);
      if (a_ok)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(gd, ed);
    chk_resp(gr, er);
  endtask : rd

  // Two edges to sync plus one to the pin; six leaves margin
  task automatic pins;
    logic ea, eb;
    repeat (6) @(posedge ref_clk);
    #1;
    ea = tov ? ta : (ind(regs[1][7:4]) ~^ regs[1][3]);
    eb = tov ? tb : (ind(regs[2][7:4]) ~^ regs[2][3]);
    chk_pin(pa, ea);
    chk_pin(pb, eb);
    chk({30'h0, v1, v2}, {30'h0, regs[3][7] | !l1, regs[3][7] | !l2});
    chk({18'h0, cfg}, {18'h0, regs[0], regs[3][5:0]});
  endtask : pins

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    logic [7:0] d;
    void'($urandom(5302));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++)
      rd(addr[k]);
    pins();
    for (int i = 0; i < 12; i++)
    begin
      d = 8'($urandom);
      // Software never programs a reserved selector code
      if (i % 4 inside {1, 2})
        d[7:4] = legal[$urandom % 10];
      wr(addr[i % 4], d, (i > 7) ? 4'h0 : 4'h1);
    end
    wr(12'h068, 8'hff, 4'h1);
    for (int k = 0; k < 5; k++)
      rd(k == 4 ? 12'h068 : addr[k]);
    wr(addr[3], 8'h06, 4'h1);
    for (int c = 0; c < 16; c++)
      for (int p = 0; p < 2; p++)
        if (!(c inside {4, 5, 6, 7, 9, 12, 15}))
        begin
          @(posedge ref_clk);
          {l1, l2, lck, cal, nvm, asw} <= 6'($urandom);
          flags <= 8'($urandom);
          wr(addr[2], {c[3:0], p[0], 3'h7}, 4'h1);
          wr(addr[1], {c[3:0], !p[0], 3'h7}, 4'h1);
          pins();
        end
    wr(addr[2], 8'h08, 4'h1);
    @(posedge ref_clk);
    l1 <= 1'b1;
    l2 <= 1'b1;
    pins();
    // Bypass must force both reference valid outputs but leave the pin alone
    wr(addr[3], 8'hc6, 4'h1);
    pins();
    @(posedge ref_clk);
    tov <= 1'b1;
    ta <= 1'b1;
    pins();
    @(posedge ref_clk);
    ta <= 1'b0;
    tb <= 1'b1;
    pins();
    @(posedge ref_clk);
    tov <= 1'b0;
    rbyp <= 1'b0;
    tbyp <= 1'b0;
    for (int r = 0; r < 2; r++)
    begin
      wr(addr[1], {r ? 4'hb : 4'h3, 4'h8}, 4'h1);
      wr(addr[2], 8'h48, 4'h1);
      repeat (6) @(posedge ref_clk);
      sa = fa;
      sb = fb;
      repeat (3)
      begin
        {rdc, fdc, tdc} <= 3'h7;
        repeat (4) @(posedge ref_clk);
        {rdc, fdc, tdc} <= 3'h0;
        repeat (4) @(posedge ref_clk);
      end
      repeat (6) @(posedge ref_clk);
      chk(32'(fa - sa), 32'h3);
      chk(32'(fb - sb), 32'h3);
    end
    give_verdict();
  end
endmodule : rdsc_top_tb_top
